// >>> design/pms_pkg.sv
/*
 * Constants for the operating-mode and reset sequencer: register map,
 * field positions, reset values, input-sync indices and timing counts.
 * Assumes a 32-bit APB host and a 20 MHz pclk.
 */
// Summary of operation
// - Analog supply below its reset level sets the low-voltage reset flag.
// - Any analog reset condition holds reset mode and drives reset output low.
// - Entering reset mode returns the control and lifetime registers to their defaults.
// - Cause of the latest reset is kept in the power status register.
// - Wake-ups land in intermediate mode; low-power may be re-entered from there.
// - Writing 00 from intermediate mode moves to normal and the link clock.
// - Lifetime count unreadable in intermediate mode; it restarts counting from 0.
// - Every stop or sleep wake-up clears the window watchdog like a reset.
// - Writing 10 enters sleep: armed wake sources only, microcontroller supply off.
// - Sleep wake: flag the source at the wake, wait for regulators good, then release reset.
// - Writing 01 enters stop only after the link clock has halted.
// - After a stop command, serial and timer registers are read-only until normal.
// - Stop wake: flag set at the wake; after regulators are good, link wake irq, then main supply.
// - Battery undervoltage raises an irq; cranking threshold used when enabled.
// - Cranking entered by command from normal, or low supply during stop.
// - Cranking gates the internal oscillator while supply is low.
// - Leaving cranking looks like an undervoltage wake into intermediate mode.
// - Link supply and main regulator off in low power; clamp in stop, stop wake and cranking.
package pms_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] LIFETIME_ADDR = 8'h08;

	// Control register fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_CRANK_EN_BIT = 2;
	localparam int CTRL_CRANK_CMD_BIT = 3;
	localparam int CTRL_WAKE_EN_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Status register fields
	localparam int ST_LVR_BIT = 0;
	localparam int ST_WDOG_BIT = 1;
	localparam int ST_EXT_BIT = 2;
	localparam int ST_UV_BIT = 3;
	localparam int ST_WAKE_LSB = 8;
	localparam int ST_MODE_LSB = 16;

	localparam logic [1:0] MODE_NORMAL = 2'h0;
	localparam logic [1:0] MODE_STOP = 2'h1;
	localparam logic [1:0] MODE_SLEEP = 2'h2;
	localparam logic [1:0] MODE_UNUSED = 2'h3;

	localparam int WAKE_W = 8;

	// Indices into the synchronised input vector
	localparam int IN_POR = 0;
	localparam int IN_WDOG = 1;
	localparam int IN_EXT = 2;
	localparam int IN_REGS_OK = 3;
	localparam int IN_UV = 4;
	localparam int IN_CRANK = 5;
	localparam int IN_LINK_CLK = 6;
	localparam int IN_WAKE_LSB = 7;
	localparam int IN_W = 15;

	localparam int CLK_NS = 50;
	localparam int LINK_IDLE_NS = 2000;
	localparam int LINK_IDLE_CYC = (LINK_IDLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int IDLE_W = 8;
endpackage : pms_pkg

// >>> design/pms_sequencer.sv
/*
 * Operating-mode and reset sequencer with an APB register slave.
 * Assumes pin-level inputs are asynchronous to pclk (three-stage sync) and
 * the lifetime tick comes from logic on pclk. The die link clock is sampled.
 */
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module pms_sequencer #(
	parameter int WAKE_W = pms_pkg::WAKE_W,
	parameter int LIFE_W = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic analog_por_low,
	input wire logic wdog_expired,
	input wire logic ext_reset_req,
	input wire logic regs_above_threshold,
	input wire logic battery_below_uv,
	input wire logic battery_below_crank,
	input wire logic die_link_clock,
	input wire logic [WAKE_W-1:0] wake_req,
	input wire logic lifetime_tick,
	output logic reset_out_n,
	output logic link_supply_en,
	output logic mcu_main_en,
	output logic mcu_clamp_en,
	output logic clk_sel_link,
	output logic osc_gate,
	output logic die_link_wake_irq,
	output logic supply_undervoltage_irq,
	output logic wdog_clear,
	output logic serial_timer_read_only
);
	if (WAKE_W != pms_pkg::WAKE_W) begin : g_wake_w_bad
		$error("WAKE_W must match the wake field");
	end
	if (LIFE_W < 1 || LIFE_W > 32) begin : g_life_w_bad
		$error("LIFE_W must be 1 to 32");
	end

	typedef enum logic [2:0] {
		PMS_RESET, PMS_NORMAL, PMS_STOP_WAIT, PMS_STOP,
		PMS_SLEEP, PMS_WAKE, PMS_INTER, PMS_CRANK
	} pms_state_t;

	pms_state_t state_reg;
	logic from_stop_reg;
	logic [pms_pkg::IN_W-1:0] in_raw;
	logic [pms_pkg::IN_W-1:0] s1_reg;
	logic [pms_pkg::IN_W-1:0] s2_reg;
	logic [pms_pkg::IN_W-1:0] s3_reg;
	logic [pms_pkg::IN_W-1:0] filt_reg;
	logic link_prev_reg;
	logic [pms_pkg::IDLE_W-1:0] idle_reg;
	logic link_halted;
	logic [31:0] ctrl_reg;
	logic [31:0] status_reg;
	logic [LIFE_W-1:0] lifetime_reg;
	logic wr_acc;
	logic rd_acc;
	logic ctrl_wr;
	logic [1:0] mode_wr;
	logic rst_cond;
	logic [WAKE_W-1:0] wake_hit;
	logic crank_low;
	logic uv_low;

	assign in_raw = {wake_req, die_link_clock, battery_below_crank, battery_below_uv,
		regs_above_threshold, ext_reset_req, wdog_expired, analog_por_low};

	// Third stage guards against a single metastable sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= in_raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_reg <= '0;
		end else begin
			for (int i = 0; i < pms_pkg::IN_W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					filt_reg[i] <= s3_reg[i];
				end
			end
		end
	end

	assign rst_cond = filt_reg[pms_pkg::IN_POR] | filt_reg[pms_pkg::IN_WDOG] |
		filt_reg[pms_pkg::IN_EXT];
	assign crank_low = filt_reg[pms_pkg::IN_CRANK];
	assign uv_low = filt_reg[pms_pkg::IN_UV];
	assign wake_hit = filt_reg[pms_pkg::IN_WAKE_LSB +: WAKE_W] &
		ctrl_reg[pms_pkg::CTRL_WAKE_EN_LSB +: WAKE_W];

	// Link clock halt detection: no sampled edge for the idle time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_prev_reg <= 1'b0;
			idle_reg <= '0;
		end else begin
			link_prev_reg <= filt_reg[pms_pkg::IN_LINK_CLK];
			if (filt_reg[pms_pkg::IN_LINK_CLK] != link_prev_reg) begin
				idle_reg <= '0;
			end else if (!link_halted) begin
				idle_reg <= idle_reg + 1'b1;
			end
		end
	end
	assign link_halted = (idle_reg >= pms_pkg::IDLE_W'(pms_pkg::LINK_IDLE_CYC));

	// APB: one wait state, writes and reads complete when pready is high
	assign wr_acc = psel & penable & pready & pwrite;
	assign rd_acc = psel & penable & ~pready & ~pwrite;
	assign ctrl_wr = wr_acc && (paddr == pms_pkg::CTRL_ADDR);
	assign mode_wr = pwdata[pms_pkg::CTRL_MODE_LSB +: 2];

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == pms_pkg::CTRL_ADDR) || (a == pms_pkg::STATUS_ADDR) ||
			(a == pms_pkg::LIFETIME_ADDR);
	endfunction : addr_ok

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~addr_ok(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (rd_acc) begin
			if (paddr == pms_pkg::CTRL_ADDR) begin
				prdata <= ctrl_reg;
			end else if (paddr == pms_pkg::STATUS_ADDR) begin
				prdata <= status_reg;
			end else if (paddr == pms_pkg::LIFETIME_ADDR && state_reg != PMS_INTER) begin
				prdata <= 32'(lifetime_reg);
			end else begin
				prdata <= '0;
			end
		end else begin
			prdata <= '0;
		end
	end

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= pms_pkg::CTRL_RESET;
		end else if (state_reg == PMS_RESET) begin
			ctrl_reg <= pms_pkg::CTRL_RESET;
		end else if (ctrl_wr) begin
			ctrl_reg[pms_pkg::CTRL_CRANK_EN_BIT] <= pwdata[pms_pkg::CTRL_CRANK_EN_BIT];
			ctrl_reg[pms_pkg::CTRL_WAKE_EN_LSB +: WAKE_W] <=
				pwdata[pms_pkg::CTRL_WAKE_EN_LSB +: WAKE_W];
			if (mode_wr != pms_pkg::MODE_UNUSED) begin
				ctrl_reg[pms_pkg::CTRL_MODE_LSB +: 2] <= mode_wr;
			end
		end
	end

	// Mode sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= PMS_RESET;
			from_stop_reg <= 1'b0;
		end else if (rst_cond) begin
			state_reg <= PMS_RESET;
		end else begin
			case (state_reg)
				PMS_RESET: begin
					state_reg <= PMS_NORMAL;
				end
				PMS_NORMAL: begin
					if (ctrl_wr && pwdata[pms_pkg::CTRL_CRANK_CMD_BIT]) begin
						state_reg <= PMS_CRANK;
					end else if (ctrl_wr && mode_wr == pms_pkg::MODE_STOP) begin
						state_reg <= PMS_STOP_WAIT;
					end else if (ctrl_wr && mode_wr == pms_pkg::MODE_SLEEP) begin
						state_reg <= PMS_SLEEP;
					end
				end
				PMS_STOP_WAIT: begin
					if (ctrl_wr && mode_wr == pms_pkg::MODE_NORMAL) begin
						state_reg <= PMS_NORMAL;
					end else if (ctrl_reg[pms_pkg::CTRL_CRANK_EN_BIT] && crank_low) begin
						state_reg <= PMS_CRANK;
					end else if (link_halted) begin
						state_reg <= PMS_STOP;
					end
				end
				PMS_STOP: begin
					if (ctrl_reg[pms_pkg::CTRL_CRANK_EN_BIT] && crank_low) begin
						state_reg <= PMS_CRANK;
					end else if (wake_hit != '0) begin
						from_stop_reg <= 1'b1;
						state_reg <= PMS_WAKE;
					end
				end
				PMS_SLEEP: begin
					if (wake_hit != '0) begin
						from_stop_reg <= 1'b0;
						state_reg <= PMS_WAKE;
					end
				end
				PMS_WAKE: begin
					if (filt_reg[pms_pkg::IN_REGS_OK]) begin
						state_reg <= PMS_INTER;
					end
				end
				PMS_INTER: begin
					if (ctrl_wr && mode_wr == pms_pkg::MODE_NORMAL) begin
						state_reg <= PMS_NORMAL;
					end else if (ctrl_wr && mode_wr == pms_pkg::MODE_STOP) begin
						state_reg <= PMS_STOP_WAIT;
					end else if (ctrl_wr && mode_wr == pms_pkg::MODE_SLEEP) begin
						state_reg <= PMS_SLEEP;
					end
				end
				PMS_CRANK: begin
					if (!crank_low) begin
						from_stop_reg <= 1'b1;
						state_reg <= PMS_INTER;
					end
				end
				default: begin
					state_reg <= PMS_RESET;
				end
			endcase
		end
	end

	// Status: hardware set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= '0;
			status_reg[pms_pkg::ST_LVR_BIT] <= 1'b1;
		end else begin
			if (wr_acc && paddr == pms_pkg::STATUS_ADDR) begin
				status_reg[pms_pkg::ST_UV_BIT:0] <=
					status_reg[pms_pkg::ST_UV_BIT:0] & ~pwdata[pms_pkg::ST_UV_BIT:0];
				status_reg[pms_pkg::ST_WAKE_LSB +: WAKE_W] <=
					status_reg[pms_pkg::ST_WAKE_LSB +: WAKE_W] &
					~pwdata[pms_pkg::ST_WAKE_LSB +: WAKE_W];
			end
			if (filt_reg[pms_pkg::IN_POR]) begin
				status_reg[pms_pkg::ST_LVR_BIT] <= 1'b1;
			end
			if (filt_reg[pms_pkg::IN_WDOG]) begin
				status_reg[pms_pkg::ST_WDOG_BIT] <= 1'b1;
			end
			if (filt_reg[pms_pkg::IN_EXT]) begin
				status_reg[pms_pkg::ST_EXT_BIT] <= 1'b1;
			end
			if (state_reg == PMS_CRANK && !crank_low) begin
				status_reg[pms_pkg::ST_UV_BIT] <= 1'b1;
			end
			if ((state_reg == PMS_STOP || state_reg == PMS_SLEEP) && wake_hit != '0) begin
				status_reg[pms_pkg::ST_WAKE_LSB +: WAKE_W] <=
					status_reg[pms_pkg::ST_WAKE_LSB +: WAKE_W] | wake_hit;
			end
			status_reg[pms_pkg::ST_MODE_LSB +: 3] <= state_reg;
		end
	end

	// Lifetime counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lifetime_reg <= '0;
		end else if (state_reg == PMS_RESET) begin
			lifetime_reg <= '0;
		end else if (state_reg == PMS_WAKE || state_reg == PMS_CRANK) begin
			lifetime_reg <= '0;
		end else if (wr_acc && paddr == pms_pkg::LIFETIME_ADDR && state_reg == PMS_NORMAL) begin
			lifetime_reg <= pwdata[LIFE_W-1:0];
		end else if (lifetime_tick) begin
			lifetime_reg <= lifetime_reg + 1'b1;
		end
	end

	// Supplies, clock select and reset output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_out_n <= 1'b0;
			link_supply_en <= 1'b1;
			mcu_main_en <= 1'b1;
			mcu_clamp_en <= 1'b0;
			clk_sel_link <= 1'b0;
			osc_gate <= 1'b0;
		end else begin
			// reset held low; sleep has no mcu supply
			reset_out_n <= !(rst_cond || state_reg == PMS_RESET || state_reg == PMS_SLEEP ||
				(state_reg == PMS_WAKE && !from_stop_reg));
			link_supply_en <= !(state_reg == PMS_STOP || state_reg == PMS_SLEEP ||
				state_reg == PMS_CRANK);
			// main regulator back after stop wake
			mcu_main_en <= !(state_reg == PMS_STOP || state_reg == PMS_SLEEP ||
				state_reg == PMS_CRANK || state_reg == PMS_WAKE);
			mcu_clamp_en <= (state_reg == PMS_STOP || state_reg == PMS_CRANK ||
				(state_reg == PMS_WAKE && from_stop_reg));
			clk_sel_link <= (state_reg == PMS_NORMAL);
			osc_gate <= (state_reg == PMS_CRANK);
		end
	end

	// Events towards the microcontroller
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			die_link_wake_irq <= 1'b0;
			wdog_clear <= 1'b1;
			supply_undervoltage_irq <= 1'b0;
			serial_timer_read_only <= 1'b0;
		end else begin
			if (state_reg == PMS_WAKE && from_stop_reg && filt_reg[pms_pkg::IN_REGS_OK]) begin
				die_link_wake_irq <= 1'b1;
			end else if (ctrl_wr || state_reg == PMS_RESET) begin
				die_link_wake_irq <= 1'b0;
			end
			wdog_clear <= (state_reg == PMS_RESET) ||
				(state_reg == PMS_WAKE && filt_reg[pms_pkg::IN_REGS_OK]);
			supply_undervoltage_irq <= ctrl_reg[pms_pkg::CTRL_CRANK_EN_BIT] ? crank_low : uv_low;
			// read-only from stop command until normal
			if (ctrl_wr && mode_wr == pms_pkg::MODE_STOP &&
				(state_reg == PMS_NORMAL || state_reg == PMS_INTER)) begin
				serial_timer_read_only <= 1'b1;
			end else if (state_reg == PMS_NORMAL || state_reg == PMS_RESET) begin
				serial_timer_read_only <= 1'b0;
			end
		end
	end
endmodule : pms_sequencer

// >>> verification/pms_sva.sv
/* Port checker for pms_sequencer, bound below.
 * Assumes pms_pkg is compiled first and pclk is the only clock. */
`timescale 1ns/1ps
module pms_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic wdog_expired,
	input wire logic battery_below_uv,
	input wire logic battery_below_crank,
	input wire logic reset_out_n,
	input wire logic link_supply_en,
	input wire logic mcu_main_en,
	input wire logic mcu_clamp_en,
	input wire logic clk_sel_link,
	input wire logic osc_gate,
	input wire logic die_link_wake_irq,
	input wire logic supply_undervoltage_irq,
	input wire logic wdog_clear,
	input wire logic serial_timer_read_only
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	wire logic ctrl_wr = pready && psel && pwrite && paddr == pms_pkg::CTRL_ADDR;

	a_reset_holds_mcu: assert property (wdog_expired [*8] |-> !reset_out_n)
		else $error("reset output high during a reset source");
	// Main regulator stays off whenever the clamp feeds the mcu
	a_clamp_alone: assert property (mcu_clamp_en |-> !mcu_main_en)
		else $error("clamp on together with the main regulator");
	a_crank_supplies: assert property (osc_gate |-> mcu_clamp_en && !mcu_main_en && !link_supply_en)
		else $error("cranking with a normal regulator on");
	// Stop keeps the mcu alive on the clamp
	a_clamp_no_reset: assert property (mcu_clamp_en |-> reset_out_n)
		else $error("mcu held in reset while clamp supplies it");
	a_uv_raises_irq: assert property ((battery_below_uv && battery_below_crank) [*8] |-> supply_undervoltage_irq)
		else $error("no undervoltage irq on low battery");
	a_wake_clears_dog: assert property ($rose(die_link_wake_irq) |-> wdog_clear || $past(wdog_clear) || $past(wdog_clear, 2))
		else $error("stop wake without watchdog clear");
	a_stop_wake_main: assert property ($rose(die_link_wake_irq) |-> ##[0:2] mcu_main_en && !mcu_clamp_en)
		else $error("stop wake left mcu on the clamp");
	a_stop_write_locks: assert property ($rose(serial_timer_read_only) |-> $past(ctrl_wr && pwdata[1:0] == pms_pkg::MODE_STOP))
		else $error("read-only lock without a stop write");
	a_link_after_write: assert property ($rose(clk_sel_link) && $past(reset_out_n, 2) |-> $past(ctrl_wr && pwdata[1:0] == pms_pkg::MODE_NORMAL, 2))
		else $error("link clock selected without a normal write");
	a_crank_exit: assert property (osc_gate && !battery_below_crank |-> ##[1:10] !osc_gate)
		else $error("oscillator still gated after supply recovered");
endmodule : pms_sva

bind pms_sequencer pms_sva pms_sva_i (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pready(pready),
	.wdog_expired(wdog_expired),
	.battery_below_uv(battery_below_uv),
	.battery_below_crank(battery_below_crank),
	.reset_out_n(reset_out_n),
	.link_supply_en(link_supply_en),
	.mcu_main_en(mcu_main_en),
	.mcu_clamp_en(mcu_clamp_en),
	.clk_sel_link(clk_sel_link),
	.osc_gate(osc_gate),
	.die_link_wake_irq(die_link_wake_irq),
	.supply_undervoltage_irq(supply_undervoltage_irq),
	.wdog_clear(wdog_clear),
	.serial_timer_read_only(serial_timer_read_only)
);

// >>> verification/pms_mcu_model.sv
/* Microcontroller die as seen on the die link: makes the link clock.
 * Assumes the bench says when the mcu runs or sits in stop. */
`timescale 1ns/1ps
module pms_mcu_model (
	input wire logic run,
	output logic die_link_clock
);
	initial begin
		die_link_clock = 1'b0;
		forever begin
			#200;
			// mcu stop halts the link clock
			if (run) begin
				die_link_clock = ~die_link_clock;
			end
		end
	end
endmodule : pms_mcu_model

// >>> verification/pms_sequencer_test.sv
/* Self-checking bench for pms_sequencer: APB tasks and mode sequences.
 * Assumes the bound checker and pms_mcu_model for the link clock. */
`timescale 1ns/1ps
module pms_sequencer_test;
	logic pclk, presetn, psel, penable, pwrite, regs_ok, uv, crank, tick, run, perr;
	logic [7:0] paddr, wake;
	logic [31:0] pwdata, r;
	logic [2:0] src;
	wire logic pready, pslverr, rst_n, link_en, main_en, clamp_en, clk_sel, osc, wirq, uv_irq, ro, link_clk;
	wire logic [31:0] prdata;
	wire logic [7:0] pins = {rst_n, link_en, main_en, clamp_en, clk_sel, osc, wirq, ro};
	int errors = 0;
	int comparisons = 0;

	pms_sequencer pms_sequencer_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.analog_por_low(src[0]), .wdog_expired(src[1]), .ext_reset_req(src[2]),
		.regs_above_threshold(regs_ok), .battery_below_uv(uv), .battery_below_crank(crank),
		.die_link_clock(link_clk), .wake_req(wake), .lifetime_tick(tick), .reset_out_n(rst_n),
		.link_supply_en(link_en), .mcu_main_en(main_en), .mcu_clamp_en(clamp_en),
		.clk_sel_link(clk_sel), .osc_gate(osc), .die_link_wake_irq(wirq),
		.supply_undervoltage_irq(uv_irq), .wdog_clear(), .serial_timer_read_only(ro)
	);
	pms_mcu_model pms_mcu_model_i (.run(run), .die_link_clock(link_clk));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic close_out();
		if (errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Holds the request until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
		end
		r = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(r & m, e);
	endtask : rd

	initial begin
		{presetn, psel, penable, pwrite, uv, crank, tick} = 7'h00;
		{regs_ok, run} = 2'h3;
		paddr = 8'h00;
		pwdata = 32'h0;
		wake = 8'h00;
		src = 3'h0;
		cyc(4);
		presetn <= 1'b1;
		cyc(8);
		rd(8'h04, 32'h0007_000F, 32'h0001_0001);
		check(32'(pins), 32'hE8);
		apb(1'b1, 8'h04, 32'h0000_0001);
		rd(8'h04, 32'h0000_0001, 32'h0);
		apb(1'b0, 8'h0C, 32'h0);
		check({r[30:0], perr}, 32'h1);
		apb(1'b1, 8'h00, 32'h0000_0103);
		rd(8'h00, 32'h0000_FF03, 32'h0000_0100);
		rd(8'h04, 32'h0007_0000, 32'h0001_0000);
		tick <= 1'b1;
		cyc(3);
		tick <= 1'b0;
		rd(8'h08, 32'hFFFF_FFFF, 32'h3);
		// nothing pending when stop is written
		apb(1'b1, 8'h00, 32'h0000_0101);
		check(32'(pins & 8'h01), 32'h1);
		rd(8'h04, 32'h0007_0000, 32'h0002_0000);
		run <= 1'b0;
		regs_ok <= 1'b0;
		cyc(60);
		check(32'(pins), 32'h91);
		wake <= 8'h01;
		cyc(10);
		check(32'(pins & 8'h02), 32'h0);
		regs_ok <= 1'b1;
		cyc(10);
		check(32'(pins), 32'hE3);
		wake <= 8'h00;
		rd(8'h04, 32'h0007_FF00, 32'h0006_0100);
		// Ticks in intermediate count but must stay hidden
		tick <= 1'b1;
		cyc(2);
		tick <= 1'b0;
		rd(8'h08, 32'hFFFF_FFFF, 32'h0);
		apb(1'b1, 8'h04, 32'h0000_0100);
		run <= 1'b1;
		cyc(10);
		apb(1'b1, 8'h00, 32'h0000_0100);
		// Outputs follow the new mode one edge after the write lands
		cyc(1);
		check(32'(pins), 32'hE8);
		rd(8'h08, 32'hFFFF_FFFF, 32'h2);
		apb(1'b1, 8'h00, 32'h0000_0102);
		regs_ok <= 1'b0;
		cyc(8);
		check(32'(pins), 32'h00);
		wake <= 8'h02;
		cyc(10);
		check(32'(pins), 32'h00);
		wake <= 8'h01;
		cyc(10);
		regs_ok <= 1'b1;
		cyc(10);
		wake <= 8'h00;
		check(32'(pins), 32'hE0);
		rd(8'h04, 32'h0007_FF00, 32'h0006_0100);
		apb(1'b1, 8'h04, 32'h0000_0100);
		apb(1'b1, 8'h00, 32'h0000_0100);
		uv <= 1'b1;
		cyc(10);
		check(32'(uv_irq), 32'h1);
		crank <= 1'b1;
		cyc(8);
		apb(1'b1, 8'h00, 32'h0000_010C);
		cyc(4);
		check(32'(pins & 8'h04), 32'h04);
		{uv, crank} <= 2'h0;
		cyc(12);
		check(32'(pins & 8'h04), 32'h0);
		rd(8'h04, 32'h0007_0008, 32'h0006_0008);
		// Cranking enabled: only the lower threshold raises the irq
		uv <= 1'b1;
		cyc(10);
		check(32'(uv_irq), 32'h0);
		crank <= 1'b1;
		cyc(8);
		apb(1'b1, 8'h00, 32'h0000_0105);
		cyc(4);
		check(32'(pins & 8'h04), 32'h04);
		{uv, crank} <= 2'h0;
		cyc(12);
		apb(1'b1, 8'h00, 32'h0000_0100);
		// Stop request withdrawn while the link clock still runs
		apb(1'b1, 8'h00, 32'h0000_0101);
		apb(1'b1, 8'h00, 32'h0000_0100);
		rd(8'h04, 32'h0007_0000, 32'h0001_0000);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 8'h04, 32'h0000_000F);
			apb(1'b1, 8'h00, 32'h0000_0100);
			src <= 3'(1 << i);
			cyc(10);
			check(32'(pins & 8'h80), 32'h0);
			src <= 3'h0;
			cyc(12);
			rd(8'h04, 32'h0007_000F, 32'h0001_0000 | (32'h1 << i));
			rd(8'h00, 32'hFFFF_FFFF, 32'h0);
		end
		close_out();
	end

	// Whole sequence needs well under a millisecond
	initial begin
		#1_000_000;
		errors++;
		close_out();
	end
endmodule : pms_sequencer_test
